//--- rtl/wwdcfg_regs.vh
// register offsets, field positions, reset values and timing counts of the
// windowed watchdog configuration block; definitions only.
`ifndef WWDCFG_REGS_VH
`define WWDCFG_REGS_VH

// ---------------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ---------------------------------------------------------------------
`define WWDCFG_OFF_CTRL0 12'h000
`define WWDCFG_OFF_CTRL1 12'h004
`define WWDCFG_OFF_PSLO 12'h008
`define WWDCFG_OFF_PSHI 12'h00c
`define WWDCFG_OFF_TMR 12'h010

// ---------------------------------------------------------------------
// field positions and codes
// ---------------------------------------------------------------------
`define WWDCFG_SEN_BIT 0
`define WWDCFG_TS_LSB 1
`define WWDCFG_TS_MSB 5
`define WWDCFG_CS_LSB 4
`define WWDCFG_CS_MSB 6
`define WWDCFG_WIN_LSB 0
`define WWDCFG_WIN_MSB 2
`define WWDCFG_TS_ALLONES 5'h1f
`define WWDCFG_TS_DEFAULT 5'h0b
`define WWDCFG_TS_MAXCODE 5'h12
`define WWDCFG_CS_SWCTRL 3'h7
`define WWDCFG_CS_LFOSC 3'h0
`define WWDCFG_CS_MFOSC 3'h1
`define WWDCFG_WIN_SWCTRL 3'h7
`define WWDCFG_EN_OFF 2'h0
`define WWDCFG_EN_SW 2'h1

// ---------------------------------------------------------------------
// timebase: oscillator rates in hz and the system clock in hz
// ---------------------------------------------------------------------
`define WWDCFG_PCLK_HZ 50000000
`define WWDCFG_LF_HZ 31000
`define WWDCFG_MF_HZ 31250
`define WWDCFG_LF_DIV (`WWDCFG_PCLK_HZ / `WWDCFG_LF_HZ)
`define WWDCFG_MF_DIV (`WWDCFG_PCLK_HZ / `WWDCFG_MF_HZ)

`endif

//--- rtl/wwdcfg_tick.v
// tick generator: divides pclk down to a watchdog oscillator rate.
// assumes pclk is the only clock; restart zeroes the phase.
`timescale 1ns/1ns
module wwdcfg_tick #(
   parameter DIV_LF = 1612,
   parameter DIV_MF = 1600
) (
   input wire pclk,
   input wire presetn,
   input wire sel_mf,
   input wire restart,
   output reg tick_ff
);
   reg [15:0] cnt_ff;
   wire [15:0] lim = sel_mf ? DIV_MF[15:0] - 16'h0001 : DIV_LF[15:0] - 16'h0001;

   // free divider; an approximate rate is all the watchdog needs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (restart) begin
         cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= lim) begin
         cnt_ff <= 16'h0000;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         tick_ff <= 1'b0;
      end
   end
endmodule // wwdcfg_tick

//--- rtl/wwdcfg_prescale.v
// prescale counter: 18-bit count of oscillator ticks, wraps at the
// selected ratio and pulses period_ff. assumes tick is one cycle wide.
`timescale 1ns/1ns
`include "wwdcfg_regs.vh"
module wwdcfg_prescale #(
   parameter PS_W = 18
) (
   input wire pclk,
   input wire presetn,
   input wire tick,
   input wire run,
   input wire clear,
   input wire [4:0] scale,
   output reg [PS_W-1:0] count_ff,
   output reg period_ff
);
   reg [23:0] ratio;
   reg [23:0] wide;
   reg [23:0] nxt_acc;
   reg [23:0] acc_ff;

   // ratio 2^(n+5); reserved codes fall back to the 1:32 minimum
   always @* begin
      if (scale > `WWDCFG_TS_MAXCODE)
         ratio = 24'h000020;
      else
         ratio = 24'h000020 << scale;
      wide = acc_ff + 24'h000001;
      nxt_acc = wide & (ratio - 24'h000001);
   end

   // the full phase is kept inside, so ratios beyond the exposed
   // bits still reach their period end; the port shows the low bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= 24'h000000;
         count_ff <= {PS_W{1'b0}};
         period_ff <= 1'b0;
      end else if (clear || !run) begin
         acc_ff <= 24'h000000;
         count_ff <= {PS_W{1'b0}};
         period_ff <= 1'b0;
      end else if (tick) begin
         acc_ff <= nxt_acc;
         count_ff <= nxt_acc[PS_W-1:0];
         period_ff <= (nxt_acc == 24'h000000);
      end else begin
         period_ff <= 1'b0;
      end
   end
endmodule // wwdcfg_prescale

//--- rtl/wwdcfg_top.v
// windowed watchdog configuration and observation registers on apb.
// assumes config word fields are static after reset and pclk at 50 mhz.
// Functional notes
// - timeout scale resets to config value, or 01011 when config is all ones.
// - timeout scale writable only when config timeout scale is all ones.
// - timebase is the 31 khz oscillator, intervals approximate.
// - clock select 000 low osc, 001 mid osc, others reserved.
// - config clock select 111 resets clock select to 000.
// - clock select writable only when config clock select is 111.
// - window code 000 closes 87.5 percent, each step 12.5 less.
// - window field resets from config window select.
// - window writable only when config window select is 111.
// - 18-bit prescale count readable in three registers, low byte resets zero.
// - control one bits 7 and 3 read zero, writes ignored.
// - armed status bit reads 1 while the watchdog is armed.
// - prescale bits 15 to 8 in a read-only high byte register.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "wwdcfg_regs.vh"
module wwdcfg_top #(
   parameter PS_W = 18,
   parameter TMR_W = 5
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] config_enable_field,
   input wire [4:0] config_timeout_scale,
   input wire [2:0] config_clock_select,
   input wire [2:0] config_window_select,
   output reg armed_ff,
   output reg [TMR_W-1:0] wdt_count_ff,
   output reg window_open_ff,
   output reg period_end_ff
);
   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   reg [4:0] timeout_scale_select_ff;
   reg software_enable_bit_ff;
   reg [2:0] timer_clock_select_ff;
   reg [2:0] window_ff;
   reg load_ff;
   reg [4:0] nxt_ts;
   reg [2:0] nxt_cs;
   reg [2:0] nxt_win;
   reg nxt_sen;
   reg [31:0] nxt_rdata;
   reg nxt_armed;
   wire setup = psel && !penable;
   wire wr_acc = psel && penable && pwrite && pready;
   wire tick;
   wire period;
   wire [PS_W-1:0] prescale_count;
   wire ts_wr_ok = (config_timeout_scale == `WWDCFG_TS_ALLONES);
   wire cs_wr_ok = (config_clock_select == `WWDCFG_CS_SWCTRL);
   wire win_wr_ok = (config_window_select == `WWDCFG_WIN_SWCTRL);
   wire settings_change = (nxt_ts != timeout_scale_select_ff) ||
      (nxt_cs != timer_clock_select_ff) || (nxt_win != window_ff);

   // -------------------------------------------------------------------
   // register writes with config-word gating
   // -------------------------------------------------------------------
   always @* begin
      nxt_ts = timeout_scale_select_ff;
      nxt_cs = timer_clock_select_ff;
      nxt_win = window_ff;
      nxt_sen = software_enable_bit_ff;
      if (wr_acc && paddr == `WWDCFG_OFF_CTRL0) begin
         nxt_sen = pwdata[`WWDCFG_SEN_BIT];
         if (ts_wr_ok)
            nxt_ts = pwdata[`WWDCFG_TS_MSB:`WWDCFG_TS_LSB];
      end
      if (wr_acc && paddr == `WWDCFG_OFF_CTRL1) begin
         // bits 7 and 3 are not stored at all
         if (cs_wr_ok)
            nxt_cs = pwdata[`WWDCFG_CS_MSB:`WWDCFG_CS_LSB];
         if (win_wr_ok)
            nxt_win = pwdata[`WWDCFG_WIN_MSB:`WWDCFG_WIN_LSB];
      end
   end

   // reset values come from config words, caught one edge after release
   // since an async reset may only load constants
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_ff <= 1'b1;
         timeout_scale_select_ff <= `WWDCFG_TS_DEFAULT;
         timer_clock_select_ff <= `WWDCFG_CS_LFOSC;
         window_ff <= 3'h0;
         software_enable_bit_ff <= 1'b0;
      end else if (load_ff) begin
         load_ff <= 1'b0;
         timeout_scale_select_ff <= ts_wr_ok ? `WWDCFG_TS_DEFAULT :
            config_timeout_scale;
         timer_clock_select_ff <= cs_wr_ok ? `WWDCFG_CS_LFOSC :
            config_clock_select;
         window_ff <= config_window_select;
      end else begin
         timeout_scale_select_ff <= nxt_ts;
         timer_clock_select_ff <= nxt_cs;
         window_ff <= nxt_win;
         software_enable_bit_ff <= nxt_sen;
      end
   end

   // -------------------------------------------------------------------
   // arming and timebase
   // -------------------------------------------------------------------
   always @* begin
      case (config_enable_field)
         `WWDCFG_EN_OFF: nxt_armed = 1'b0;
         `WWDCFG_EN_SW: nxt_armed = software_enable_bit_ff;
         default: nxt_armed = 1'b1;
      endcase
      // reserved source codes leave the timer stopped
      if (timer_clock_select_ff != `WWDCFG_CS_LFOSC &&
          timer_clock_select_ff != `WWDCFG_CS_MFOSC)
         nxt_armed = 1'b0;
      if (load_ff)
         nxt_armed = 1'b0;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         armed_ff <= 1'b0;
      else
         armed_ff <= nxt_armed;
   end

   // dividers approximate the low and mid oscillators from pclk
   wwdcfg_tick #(
      .DIV_LF(`WWDCFG_LF_DIV),
      .DIV_MF(`WWDCFG_MF_DIV)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .sel_mf(timer_clock_select_ff == `WWDCFG_CS_MFOSC),
      .restart(settings_change),
      .tick_ff(tick)
   );

   wwdcfg_prescale #(
      .PS_W(PS_W)
   ) u_ps (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .run(armed_ff),
      .clear(settings_change),
      .scale(timeout_scale_select_ff),
      .count_ff(prescale_count),
      .period_ff(period)
   );

   // -------------------------------------------------------------------
   // watchdog period counter and window
   // -------------------------------------------------------------------
   // eight slots per period; window code w opens from slot 7-w onward
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_count_ff <= {TMR_W{1'b0}};
         window_open_ff <= 1'b0;
         period_end_ff <= 1'b0;
      end else if (settings_change || !armed_ff) begin
         wdt_count_ff <= {TMR_W{1'b0}};
         window_open_ff <= 1'b0;
         period_end_ff <= 1'b0;
      end else begin
         period_end_ff <= period && (wdt_count_ff[2:0] == 3'h7);
         if (period)
            wdt_count_ff <= wdt_count_ff + {{(TMR_W-1){1'b0}}, 1'b1};
         window_open_ff <= (window_ff == `WWDCFG_WIN_SWCTRL) ||
            ({1'b0, wdt_count_ff[2:0]} >= (4'h7 - {1'b0, window_ff}));
      end
   end

   // -------------------------------------------------------------------
   // apb read mux and handshake
   // -------------------------------------------------------------------
   always @* begin
      nxt_rdata = 32'h0000_0000;
      case (paddr)
         `WWDCFG_OFF_CTRL0: nxt_rdata[5:0] = {timeout_scale_select_ff, software_enable_bit_ff};
         `WWDCFG_OFF_CTRL1: nxt_rdata[7:0] = {1'b0, timer_clock_select_ff,
            1'b0, window_ff};
         `WWDCFG_OFF_PSLO: nxt_rdata[7:0] = prescale_count[7:0];
         `WWDCFG_OFF_PSHI: nxt_rdata[7:0] = prescale_count[15:8];
         `WWDCFG_OFF_TMR: nxt_rdata[7:0] = {wdt_count_ff, armed_ff,
            prescale_count[PS_W-1:16]};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // no wait state: answer registered in setup, ready in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= setup ? nxt_rdata : 32'h0000_0000;
         pslverr <= setup && (paddr > `WWDCFG_OFF_TMR || paddr[1:0] != 2'h0);
      end
   end
endmodule // wwdcfg_top

//--- bench/wwdcfg_props.sv
// checker for the watchdog configuration block: apb timing, read gaps, armed status.
// assumes the single clock pclk and the async active-low reset presetn.
`timescale 1ns/1ns
module wwdcfg_props #(
   parameter PS_W = 18,
   parameter TMR_W = 5
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [1:0] config_enable_field,
   input wire [4:0] config_timeout_scale,
   input wire [2:0] config_clock_select,
   input wire [2:0] config_window_select,
   input wire armed_ff,
   input wire [TMR_W-1:0] wdt_count_ff,
   input wire window_open_ff,
   input wire period_end_ff
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // bus phases
   // ---------------------------------------------------------------
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence bad_addr_s;
      setup_s ##0 (paddr > 12'h010 || paddr[1:0] != 2'h0);
   endsequence
   // the answer comes in the access cycle and lasts one cycle only
   ready_after_setup_a: assert property (setup_s |=> pready && psel && penable)
      else $error("no answer in the access cycle");
   ready_single_a: assert property (pready |=> !pready)
      else $error("answer held longer than one cycle");
   err_unmapped_a: assert property (bad_addr_s |=> pslverr)
      else $error("unmapped address not flagged");
   err_mapped_a: assert property (setup_s ##0 (paddr <= 12'h010 && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped address flagged");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside the access cycle");
   ctrl1_gaps_a: assert property (setup_s ##0 (!pwrite && paddr == 12'h004)
      |=> prdata[31:7] == 25'h0 && !prdata[3])
      else $error("unimplemented control one bits read nonzero");
   // armed status read back is the level seen during setup
   armed_read_a: assert property (setup_s ##0 (!pwrite && paddr == 12'h010)
      |=> prdata[2] == $past(armed_ff))
      else $error("armed bit read differs from status");
   armed_off_a: assert property (config_enable_field == 2'h0 |-> !armed_ff)
      else $error("armed although the config disables it");
   pulse_single_a: assert property (period_end_ff |=> !period_end_ff)
      else $error("period end pulse longer than one cycle");
endmodule // wwdcfg_props

bind wwdcfg_top wwdcfg_props #(.PS_W(PS_W), .TMR_W(TMR_W)) wwdcfg_props_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .config_enable_field(config_enable_field), .config_timeout_scale(config_timeout_scale),
   .config_clock_select(config_clock_select), .config_window_select(config_window_select),
   .armed_ff(armed_ff), .wdt_count_ff(wdt_count_ff), .window_open_ff(window_open_ff),
   .period_end_ff(period_end_ff));

//--- bench/wwdcfg_tb_top.sv
// self-checking bench for the watchdog configuration block over apb.
// assumes config fields change only while reset is held.
`timescale 1ns/1ns
module wwdcfg_tb_top;
   typedef struct packed {
      logic [1:0] en;
      logic [4:0] ts;
      logic [2:0] cs;
      logic [2:0] ws;
      logic [7:0] w0, w1, r0, r1, q0, q1;
      logic armed;
   } wwdcfg_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] config_enable_field = 2'h0;
   logic [4:0] config_timeout_scale = 5'h00;
   logic [2:0] config_clock_select = 3'h0;
   logic [2:0] config_window_select = 3'h0;
   wire [31:0] prdata;
   wire pready, pslverr, armed_ff, window_open_ff, period_end_ff;
   wire [4:0] wdt_count_ff;
   logic [31:0] q;
   logic e;
   int mismatches = 0;
   int comparisons = 0;
   // config, writes, values after reset, values after writes, armed level
   wwdcfg_row_t rows [4] = '{
      '{2'h1, 5'h1f, 3'h7, 3'h7, 8'h25, 8'h9f, 8'h16, 8'h07, 8'h25, 8'h17, 1'b1},
      '{2'h2, 5'h05, 3'h1, 3'h3, 8'h3f, 8'hff, 8'h0a, 8'h13, 8'h0b, 8'h13, 1'b1},
      '{2'h0, 5'h00, 3'h0, 3'h0, 8'h01, 8'h55, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0},
      '{2'h1, 5'h1f, 3'h7, 3'h2, 8'h03, 8'h15, 8'h16, 8'h02, 8'h03, 8'h12, 1'b1}};

   wwdcfg_top wwdcfg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .config_enable_field(config_enable_field),
      .config_timeout_scale(config_timeout_scale), .config_clock_select(config_clock_select),
      .config_window_select(config_window_select), .armed_ff(armed_ff),
      .wdt_count_ff(wdt_count_ff), .window_open_ff(window_open_ff),
      .period_end_ff(period_end_ff));

   always #10 pclk = ~pclk;

   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   // one idle edge first, so a release never meets the next setup in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // a slave that never answers counts against the run
      if (pready !== 1'b1) begin
         mismatches++;
         $display("unexpected pready: expected 1, seen %b", pready);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, q);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask

   // reset held two cycles while the config word settles
   task automatic rst(input wwdcfg_row_t r);
      @(posedge pclk);
      presetn <= 1'b0;
      config_enable_field <= r.en;
      config_timeout_scale <= r.ts;
      config_clock_select <= r.cs;
      config_window_select <= r.ws;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // table of config cases, then the awkward ones on the last config
   // ---------------------------------------------------------------
   initial begin
      foreach (rows[i]) begin
         rst(rows[i]);
         rdc(12'h000, {24'h0, rows[i].r0}, "ctrl0 reset");
         rdc(12'h004, {24'h0, rows[i].r1}, "ctrl1 reset");
         apb(1'b1, 12'h000, {24'hffffff, rows[i].w0});
         apb(1'b1, 12'h004, {24'hffffff, rows[i].w1});
         rdc(12'h000, {24'h0, rows[i].q0}, "ctrl0 written");
         rdc(12'h004, {24'h0, rows[i].q1}, "ctrl1 written");
         chk("armed", {31'h0, rows[i].armed}, {31'h0, armed_ff});
         // counter sits in slot 0, so only the always-open code shows an open window
         chk("window open", {31'h0, rows[i].armed && rows[i].q1[2:0] == 3'h7},
            {31'h0, window_open_ff});
      end
      rdc(12'h00c, 32'h0, "prescale high");
      // mid oscillator ticks every 1600 cycles, so about three ticks land here
      repeat (5000) @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0);
      chk("prescale low counting", 32'h1, {31'h0, q inside {[2:4]}});
      apb(1'b1, 12'h000, 32'h05);
      rdc(12'h008, 32'h0, "prescale low restart");
      rdc(12'h010, 32'h4, "timer armed");
      apb(1'b1, 12'h014, 32'hff);
      chk("pslverr unmapped", 32'h1, {31'h0, e});
      apb(1'b0, 12'h002, 32'h0);
      chk("pslverr unaligned", 32'h1, {31'h0, e});
      rdc(12'h000, 32'h05, "ctrl0 kept");
      // a reserved source code stops the timer and drops the armed status
      apb(1'b1, 12'h004, 32'h25);
      rdc(12'h010, 32'h0, "timer reserved source");
      final_report;
   end

   // the whole run is near 5100 cycles; this cuts a hang well past that
   initial begin
      #400000;
      mismatches++;
      final_report;
   end
endmodule // wwdcfg_tb_top
